/* File: hw/ptp_stamp_top.sv */
/*
  Frame stamping datapath for peer-to-peer (modes A and B) and two-step
  transparent clock operation: analyzer, time stamp arithmetic, rewriter
  with FCS regeneration, and the Tx stamp FIFO.
  Assumes one byte per beat, valid held high without gaps inside a frame,
  frames of at least 64 bytes, and a stamp offered on STAMP_NS with SOP.
*/
`timescale 1ns/1ns
`default_nettype none
module ptp_stamp_top
  import ptp_stamp_pkg::*;
#(
  parameter int LOOKAHEAD = LOOKAHEAD_DEF,
  parameter int TS_DEPTH = TS_DEPTH_DEF
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Frame stream in, with its raw ns stamp
  input wire beat_type IN_BEAT,
  input wire logic [31:0] STAMP_NS,
  // Configuration
  input wire tc_mode_type TC_MODE,
  input wire logic EGRESS,
  input wire logic T3_FIFO_MODE,
  input wire logic [7:0] DOMAIN,
  input wire logic [31:0] LOCAL_OFFSET,
  input wire logic [31:0] ASYMMETRY,
  input wire logic [31:0] PATH_DELAY,
  // Frame stream out
  output var beat_type OUT_BEAT,
  // Status
  output var stamp_action_type FRAME_ACTION,
  output logic TS_DROPPED,
  output logic TS_FULL,
  // Stamp FIFO read port
  output logic TS_RD_VALID,
  input wire logic TS_RD_READY,
  output var ts_entry_type TS_RD_ENTRY
);
  localparam int PW = $clog2(LOOKAHEAD);
  localparam logic [PW-1:0] PTR_LAST = PW'(LOOKAHEAD - 1);

  // Analyzer side state
  parse_state_type state_r;
  parse_state_type state_nxt;
  logic [15:0] in_idx_r;
  logic [15:0] etype_r;
  logic [3:0] msg_r;
  logic [7:0] dom_r;
  logic [63:0] cf_in_r;
  logic [31:0] resv_r;
  logic [15:0] port_r;
  logic [15:0] seq_r;
  logic [31:0] crc_in_r;
  logic [15:0] in_len_r;
  logic bad_fcs_r;

  // Time stamp block state
  logic [31:0] raw_ns_stamp_r;
  logic [31:0] current_ns_stamp_reg_r;
  decision_type decision_r;
  logic [63:0] cf_new_r;
  logic [31:0] resv_new_r;
  logic save_stamp_r;
  logic [79:0] ts_id_r;
  logic ts_dropped_r;

  // Rewriter state
  beat_type ring_r [LOOKAHEAD];
  logic [PW-1:0] ptr_r;
  logic [15:0] out_idx_r;
  decision_type out_dec_r;
  logic [63:0] cf_sr_r;
  logic [31:0] resv_sr_r;
  logic [23:0] fcs_sr_r;
  logic [31:0] crc_out_r;
  beat_type out_beat_r;

  // Analyzer decode
  wire in_fire = IN_BEAT.valid;
  wire [15:0] idx_in = IN_BEAT.sop ? 16'h0000 : in_idx_r;
  wire in_sop = in_fire && IN_BEAT.sop;
  wire in_eop = in_fire && IN_BEAT.eop;
  wire decide_now = (state_r == ST_HEAD) && in_fire && !IN_BEAT.sop &&
                    (idx_in == IDX_DECIDE);
  wire is_ptp = (etype_r == PTP_ETHERTYPE) && (dom_r == DOMAIN);
  wire decision_type dec_raw = decide_action(TC_MODE, EGRESS, T3_FIFO_MODE,
                                             msg_r);
  wire decision_type dec_now = is_ptp ? dec_raw : DEC_NONE;
  wire matched = dec_now.action != ACT_NONE;
  wire [31:0] crc_in_cur = IN_BEAT.sop ? CRC_INIT : crc_in_r;
  wire [31:0] crc_in_nxt = crc_byte(crc_in_cur, IN_BEAT.data);

  // Stamp arithmetic
  wire [31:0] base_ns = EGRESS ? raw_ns_stamp_r + LOCAL_OFFSET
                               : raw_ns_stamp_r - LOCAL_OFFSET;
  wire [31:0] cur_ns = dec_now.asym_add ? base_ns + ASYMMETRY : // [R9]
                       dec_now.asym_sub ? base_ns - ASYMMETRY : // [R10] [R18]
                       base_ns;
  wire [31:0] peer_ns = raw_ns_stamp_r - LOCAL_OFFSET - PATH_DELAY -
                        ASYMMETRY; // [R7]
  // A reserved-bytes stamp from the previous second wraps the span
  wire [31:0] span_ns = (cur_ns < resv_r) ? cur_ns - resv_r + NS_PER_SEC
                                          : cur_ns - resv_r;
  logic [63:0] cf_nxt;
  wire [31:0] resv_nxt = dec_now.resv_zero ? 32'h00000000 : cur_ns; // [R9]

  always_comb begin
    case (dec_now.action)
      ACT_ADD: cf_nxt = cf_in_r + ns_to_cf(cur_ns); // [R12] [R6]
      ACT_SUB_ADD: cf_nxt = cf_in_r + ns_to_cf(span_ns); // [R2] [R4] [R6]
      ACT_PEER_SUB: cf_nxt = cf_in_r - ns_to_cf(peer_ns); // [R7]
      default: cf_nxt = dec_now.cf_asym ? cf_in_r + ns_to_cf(ASYMMETRY)
                                        : cf_in_r; // [R15]
    endcase
  end

  // FIFO feed at the end of a saved frame
  wire ts_wr_valid = in_eop && !IN_BEAT.sop && save_stamp_r; // [R13]
  wire ts_wr_ready;
  wire ts_entry_type ts_wr_entry = '{frame_id: ts_id_r,
                                     stamp: current_ns_stamp_reg_r};

  // Rewriter decode
  wire beat_type dly = ring_r[ptr_r];
  wire [15:0] idx_out = dly.sop ? 16'h0000 : out_idx_r;
  wire [15:0] fcs_start = in_len_r - FCS_BYTES;
  wire in_fcs = idx_out >= fcs_start;
  wire fcs_first = idx_out == fcs_start;
  wire out_latch = dly.valid && (idx_out == IDX_LATCH);
  wire cf_hit = dly.valid && out_dec_r.write_cf &&
                in_range(idx_out, IDX_CF, CF_BYTES); // [R1] [R7]
  wire resv_hit = dly.valid && out_dec_r.write_resv &&
                  in_range(idx_out, IDX_RESV, RESV_BYTES); // [R8] [R17]
  wire modified = out_dec_r.write_cf || out_dec_r.write_resv;
  wire [31:0] fcs_word = bad_fcs_r ? crc_out_r : ~crc_out_r; // [R19]
  wire [7:0] fcs_byte = fcs_first ? fcs_word[7:0] : fcs_sr_r[7:0];
  wire [7:0] out_byte = !dly.valid ? 8'h00 :
                        cf_hit ? cf_sr_r[63:56] :
                        resv_hit ? resv_sr_r[31:24] :
                        (modified && in_fcs) ? fcs_byte : // [R19]
                        dly.data; // [R5]
  wire [31:0] crc_out_cur = dly.sop ? CRC_INIT : crc_out_r;

  // Analyzer state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (in_sop) begin
          state_nxt = ST_HEAD;
        end
      end
      ST_HEAD: begin
        if (in_eop) begin
          state_nxt = ST_IDLE;
        end else if (decide_now) begin
          state_nxt = ST_BODY;
        end
      end
      ST_BODY: begin
        if (in_eop) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (in_sop && !IN_BEAT.eop) begin
      state_nxt = ST_HEAD;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= ST_IDLE;
      in_idx_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      if (in_fire) begin
        in_idx_r <= idx_in + 16'h0001;
      end
    end
  end

  // Header field capture
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      etype_r <= 16'h0000;
      msg_r <= 4'h0;
      dom_r <= 8'h00;
      port_r <= 16'h0000;
      seq_r <= 16'h0000;
    end else if (in_fire) begin
      if (in_range(idx_in, IDX_ETYPE, ID_BYTES)) begin
        etype_r <= {etype_r[7:0], IN_BEAT.data};
      end
      if (idx_in == IDX_MSG) begin
        msg_r <= IN_BEAT.data[3:0];
      end
      if (idx_in == IDX_DOM) begin
        dom_r <= IN_BEAT.data;
      end
      if (in_range(idx_in, IDX_PORT, ID_BYTES)) begin
        port_r <= {port_r[7:0], IN_BEAT.data};
      end
      if (in_range(idx_in, IDX_SEQ, ID_BYTES)) begin
        seq_r <= {seq_r[7:0], IN_BEAT.data};
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cf_in_r <= 64'h0000000000000000;
      resv_r <= 32'h00000000;
    end else if (in_fire) begin
      if (in_range(idx_in, IDX_CF, CF_BYTES)) begin
        cf_in_r <= {cf_in_r[55:0], IN_BEAT.data};
      end
      if (in_range(idx_in, IDX_RESV, RESV_BYTES)) begin
        resv_r <= {resv_r[23:0], IN_BEAT.data};
      end
    end
  end

  // Incoming FCS check; its verdict must outlive the lookahead
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      crc_in_r <= CRC_INIT;
      in_len_r <= 16'hFFFF;
      bad_fcs_r <= 1'b0;
    end else if (in_fire) begin
      crc_in_r <= crc_in_nxt;
      if (IN_BEAT.eop) begin
        in_len_r <= idx_in + 16'h0001;
        bad_fcs_r <= crc_in_nxt != CRC_RESIDUE; // [R19]
      end
    end
  end

  // Time stamp block: decision made once the header is in
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      raw_ns_stamp_r <= 32'h00000000;
      current_ns_stamp_reg_r <= 32'h00000000;
      decision_r <= DEC_NONE;
      cf_new_r <= 64'h0000000000000000;
      resv_new_r <= 32'h00000000;
      save_stamp_r <= 1'b0;
      ts_id_r <= 80'h0;
    end else if (in_sop) begin
      raw_ns_stamp_r <= STAMP_NS;
      decision_r <= DEC_NONE;
      save_stamp_r <= 1'b0;
    end else if (decide_now) begin
      decision_r <= dec_now; // [R20]
      cf_new_r <= cf_nxt; // [R12]
      resv_new_r <= resv_nxt; // [R9]
      current_ns_stamp_reg_r <= cur_ns; // [R13]
      save_stamp_r <= dec_now.action == ACT_WRITE_SAVE; // [R13]
      // Identifier carries the Rx stamp still held in the reserved bytes
      ts_id_r <= {seq_r, resv_r, port_r, dom_r, 4'h0, msg_r}; // [R16] [R18]
      if (!matched) begin
        raw_ns_stamp_r <= 32'h00000000; // [R5]
      end
    end else if (in_eop) begin
      save_stamp_r <= 1'b0;
    end
  end

  // Stamp lost because the engine left the FIFO full
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ts_dropped_r <= 1'b0;
    end else begin
      ts_dropped_r <= ts_wr_valid && !ts_wr_ready;
    end
  end

  // Lookahead delay line so the rewriter trails the analyzer
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ptr_r <= '0;
      for (int i = 0; i < LOOKAHEAD; i++) begin
        ring_r[i] <= '0;
      end
    end else begin
      ring_r[ptr_r] <= IN_BEAT;
      ptr_r <= (ptr_r == PTR_LAST) ? '0 : ptr_r + 1'b1;
    end
  end

  // Rewriter: decision taken just ahead of the first target byte
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      out_idx_r <= 16'h0000;
      out_dec_r <= DEC_NONE;
      cf_sr_r <= 64'h0000000000000000;
      resv_sr_r <= 32'h00000000;
    end else if (dly.valid) begin
      out_idx_r <= idx_out + 16'h0001;
      if (dly.sop) begin
        out_dec_r <= DEC_NONE;
      end else if (out_latch) begin
        out_dec_r <= decision_r; // [R20]
        cf_sr_r <= cf_new_r;
        resv_sr_r <= resv_new_r;
      end else begin
        if (cf_hit) begin
          cf_sr_r <= {cf_sr_r[55:0], 8'h00};
        end
        if (resv_hit) begin
          resv_sr_r <= {resv_sr_r[23:0], 8'h00};
        end
      end
    end
  end

  // Outgoing FCS regeneration
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      crc_out_r <= CRC_INIT;
      fcs_sr_r <= 24'h000000;
    end else if (dly.valid) begin
      if (!in_fcs) begin
        crc_out_r <= crc_byte(crc_out_cur, out_byte); // [R19]
      end
      fcs_sr_r <= fcs_first ? fcs_word[31:8] : {8'h00, fcs_sr_r[23:8]};
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      out_beat_r <= '0;
    end else begin
      out_beat_r <= '{valid: dly.valid, sop: dly.sop, eop: dly.eop,
                      data: out_byte};
    end
  end

  ts_fifo #(
    .WIDTH($bits(ts_entry_type)),
    .DEPTH(TS_DEPTH)
  ) u_ts_fifo (
    .clk(CORE_CLK),
    .reset_n(RESET_N),
    .wr_valid(ts_wr_valid),
    .wr_ready(ts_wr_ready),
    .wr_data(ts_wr_entry),
    .rd_valid(TS_RD_VALID),
    .rd_ready(TS_RD_READY),
    .rd_data(TS_RD_ENTRY),
    .full(TS_FULL)
  ); // [R14]

  assign OUT_BEAT = out_beat_r;
  assign FRAME_ACTION = decision_r.action;
  assign TS_DROPPED = ts_dropped_r;
endmodule
`default_nettype wire

/* File: hw/ptp_stamp_pkg.sv */
/*
  Constants, types and helper functions shared by the peer-to-peer and
  two-step transparent clock stamping datapath, its checker and its bench.
  Assumes untagged Ethernet frames carrying PTP directly (EtherType
  0x88F7), one byte per beat, with the FCS carried in the stream.
*/
// Summary of operation
// [R1] Egress peer Sync: Add onto correction field
// [R2] Egress mode A Pdelay_req: subtract-then-add into correction
// [R3] t3 FIFO handling: Pdelay_req saves stamp, unmodified
// [R4] Egress mode A Pdelay_resp: subtract-then-add into correction
// [R5] Unmatched frame passes untouched, stamp discarded
// [R6] Egress mode A correction formulas per message type
// [R7] Ingress peer Sync: correction minus peer-adjusted stamp
// [R8] Ingress peer Pdelay frames: Write reserved four bytes
// [R9] Write drives current stamp; resp adds asymmetry
// [R10] Egress mode B Pdelay_req: save stamp minus asymmetry
// [R11] Engine pre-subtracts Rx stamp in egress resp
// [R12] Add: correction plus current stamp to rewriter
// [R13] Write-and-Save: current stamp out, FIFO capture set
// [R14] FIFO pairs stamp with frame identifier for reading
// [R15] Two-step ingress: stamp reserved bytes, Sync asymmetry
// [R16] Two-step egress: save stamp with 10-byte identifier
// [R17] Two-step egress clears reserved bytes to zero
// [R18] Two-step egress FIFO stamp, Delay_req minus asymmetry
// [R19] Modified frame gets new FCS, bad stays bad
// [R20] Action known before rewriter reaches target field
package ptp_stamp_pkg;

  localparam logic [15:0] IDX_ETYPE = 16'h000C;
  localparam logic [15:0] PTP_ETHERTYPE = 16'h88F7;
  localparam logic [15:0] IDX_HDR = 16'h000E;
  localparam logic [15:0] IDX_MSG = IDX_HDR;
  localparam logic [15:0] IDX_DOM = IDX_HDR + 16'h0004;
  localparam logic [15:0] IDX_CF = IDX_HDR + 16'h0008;
  localparam logic [15:0] CF_BYTES = 16'h0008;
  localparam logic [15:0] IDX_RESV = IDX_HDR + 16'h0010;
  localparam logic [15:0] RESV_BYTES = 16'h0004;
  localparam logic [15:0] IDX_PORT = IDX_HDR + 16'h001C;
  localparam logic [15:0] IDX_SEQ = IDX_HDR + 16'h001E;
  localparam logic [15:0] ID_BYTES = 16'h0002;
  localparam logic [15:0] IDX_DECIDE = IDX_HDR + 16'h0020;
  localparam logic [15:0] IDX_LATCH = IDX_CF - 16'h0001;
  localparam logic [15:0] FCS_BYTES = 16'h0004;

  localparam logic [3:0] MSG_SYNC = 4'h0;
  localparam logic [3:0] MSG_DELAY_REQ = 4'h1;
  localparam logic [3:0] MSG_PDELAY_REQ = 4'h2;
  localparam logic [3:0] MSG_PDELAY_RESP = 4'h3;

  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  localparam logic [31:0] NS_PER_SEC = 32'h3B9ACA00;
  localparam int LOOKAHEAD_DEF = 32;
  localparam int TS_DEPTH_DEF = 8;

  typedef enum logic [5:0] {
    ACT_NONE = 6'h01,
    ACT_ADD = 6'h02,
    ACT_SUB_ADD = 6'h04,
    ACT_PEER_SUB = 6'h08,
    ACT_WRITE = 6'h10,
    ACT_WRITE_SAVE = 6'h20
  } stamp_action_type;

  typedef enum logic [2:0] {
    MODE_PEER_A = 3'h1,
    MODE_PEER_B = 3'h2,
    MODE_TWO_STEP = 3'h4
  } tc_mode_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_HEAD = 3'h2,
    ST_BODY = 3'h4
  } parse_state_type;

  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [7:0] data;
  } beat_type;

  typedef struct packed {
    stamp_action_type action;
    logic write_cf;
    logic write_resv;
    logic resv_zero;
    logic cf_asym;
    logic asym_add;
    logic asym_sub;
  } decision_type;

  typedef struct packed {
    logic [79:0] frame_id;
    logic [31:0] stamp;
  } ts_entry_type;

  localparam decision_type DEC_NONE = '{action: ACT_NONE, default: 1'b0};

  function automatic logic in_range(logic [15:0] idx, logic [15:0] ofs,
                                    logic [15:0] len);
    return (idx >= ofs) && (idx < ofs + len);
  endfunction

  function automatic logic [31:0] crc_byte(logic [31:0] crc, logic [7:0] d);
    logic [31:0] c;
    c = crc ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // Nanoseconds into the correction field, which holds ns scaled by 2^16
  function automatic logic [63:0] ns_to_cf(logic [31:0] ns);
    return {{16{ns[31]}}, ns, 16'h0000};
  endfunction

  function automatic decision_type decide_action(tc_mode_type mode,
      logic egress, logic t3_fifo, logic [3:0] msg);
    decision_type d;
    d = DEC_NONE;
    if (mode == MODE_TWO_STEP) begin
      if (msg == MSG_SYNC || msg == MSG_DELAY_REQ) begin
        if (egress) begin
          d.action = ACT_WRITE_SAVE; // [R16]
          d.write_resv = 1'b1; // [R17]
          d.resv_zero = 1'b1; // [R17]
          d.asym_sub = (msg == MSG_DELAY_REQ); // [R18]
        end else begin
          d.action = ACT_WRITE; // [R15]
          d.write_resv = 1'b1; // [R15]
          d.write_cf = (msg == MSG_SYNC); // [R15]
          d.cf_asym = (msg == MSG_SYNC); // [R15]
        end
      end
    end else if (egress) begin
      if (msg == MSG_SYNC) begin
        d.action = ACT_ADD; // [R1]
        d.write_cf = 1'b1; // [R1]
      end else if (msg == MSG_PDELAY_REQ) begin
        d.asym_sub = 1'b1; // [R6]
        if (mode == MODE_PEER_B || t3_fifo) begin
          d.action = ACT_WRITE_SAVE; // [R3] [R10]
        end else begin
          d.action = ACT_SUB_ADD; // [R2]
          d.write_cf = 1'b1; // [R2]
        end
      end else if (msg == MSG_PDELAY_RESP) begin
        // Mode B leans on the engine having removed the Rx stamp already
        d.action = (mode == MODE_PEER_A) ? ACT_SUB_ADD : ACT_ADD; // [R4] [R11]
        d.write_cf = 1'b1; // [R4]
      end
    end else begin
      if (msg == MSG_SYNC) begin
        d.action = ACT_PEER_SUB; // [R7]
        d.write_cf = 1'b1; // [R7]
      end else if (msg == MSG_PDELAY_REQ || msg == MSG_PDELAY_RESP) begin
        d.action = ACT_WRITE; // [R8]
        d.write_resv = 1'b1; // [R8]
        if (msg == MSG_PDELAY_RESP) begin
          d.asym_add = (mode == MODE_PEER_B); // [R9]
          d.write_cf = (mode == MODE_PEER_A);
          d.cf_asym = (mode == MODE_PEER_A);
        end
      end
    end
    return d;
  endfunction

endpackage

/* File: hw/ts_fifo.sv */
/*
  Tx time stamp FIFO: flip-flop storage of stamp and frame identifier
  sets, written by the stamping datapath and drained by the engine.
  Assumes DEPTH is a power of two and one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module ts_fifo #(
  parameter int WIDTH = 112,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // Drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data,
  // Status
  output logic full
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  wire empty = (wr_ptr_r == rd_ptr_r);
  wire wr_fire = wr_valid && wr_ready;
  wire rd_fire = rd_valid && rd_ready;

  assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign wr_ready = !full;
  assign rd_valid = !empty;
  assign rd_data = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (wr_fire) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (rd_fire) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (wr_fire) begin
      mem_r[wr_ptr_r[AW-1:0]] <= wr_data; // [R14]
    end
  end
endmodule
`default_nettype wire

/* File: bench/ptp_stamp_chk.sv */
/*
  Port checker for ptp_stamp_top: stream delay, action timing and the
  stamp FIFO. Assumes one clock domain; bound after the module.
*/
`timescale 1ns/1ns
`default_nettype none
module ptp_stamp_chk
  import ptp_stamp_pkg::*;
#(
  parameter int LOOKAHEAD = LOOKAHEAD_DEF
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Streams
  input wire beat_type IN_BEAT,
  input wire beat_type OUT_BEAT,
  // Status and FIFO
  input wire stamp_action_type FRAME_ACTION,
  input wire logic TS_DROPPED,
  input wire logic TS_FULL,
  input wire logic TS_RD_VALID,
  input wire logic TS_RD_READY,
  input wire ts_entry_type TS_RD_ENTRY
);
  localparam int DLY = LOOKAHEAD + 1;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_sop;
    IN_BEAT.valid && IN_BEAT.sop;
  endsequence
  sequence s_save_eop;
    IN_BEAT.valid && IN_BEAT.eop && FRAME_ACTION == ACT_WRITE_SAVE;
  endsequence
  a_beat_delay: assert property (IN_BEAT.valid
    |-> ##DLY OUT_BEAT.valid) else $error("beat lost in delay line");
  a_sop_delay: assert property (s_sop |-> ##DLY OUT_BEAT.sop)
    else $error("frame start lost in delay line");
  a_act_clear: assert property (s_sop |=> FRAME_ACTION == ACT_NONE)
    else $error("action not cleared at frame start");
  a_act_held: assert property (FRAME_ACTION != ACT_NONE
    && !IN_BEAT.sop |=> $stable(FRAME_ACTION))
    else $error("action changed mid frame");
  a_save_shown: assert property (s_save_eop ##0 !TS_FULL
    |=> TS_RD_VALID) else $error("saved stamp not readable");
  a_drop_cause: assert property (TS_DROPPED
    |-> $past(TS_FULL) && $past(IN_BEAT.eop)) else $error("bad drop");
  a_drop_pulse: assert property (TS_DROPPED |=> !TS_DROPPED)
    else $error("drop pulse too long");
  a_head_stable: assert property (TS_RD_VALID && !TS_RD_READY
    |=> TS_RD_VALID && $stable(TS_RD_ENTRY)) else $error("head moved");
endmodule
bind ptp_stamp_top ptp_stamp_chk #(.LOOKAHEAD(LOOKAHEAD)) u_chk (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .IN_BEAT(IN_BEAT),
  .OUT_BEAT(OUT_BEAT), .FRAME_ACTION(FRAME_ACTION), .TS_DROPPED(TS_DROPPED),
  .TS_FULL(TS_FULL), .TS_RD_VALID(TS_RD_VALID), .TS_RD_READY(TS_RD_READY),
  .TS_RD_ENTRY(TS_RD_ENTRY));
`default_nettype wire

/* File: bench/ts_engine.sv */
/*
  Engine model draining the stamp FIFO into a queue.
  Assumes the bench raises stall to let the FIFO fill.
*/
`timescale 1ns/1ns
`default_nettype none
module ts_engine
  import ptp_stamp_pkg::*;
(
  // Clock and pacing
  input wire logic clk,
  input wire logic stall,
  // FIFO read port
  input wire logic rd_valid,
  output logic rd_ready,
  input wire ts_entry_type rd_entry
);
  ts_entry_type got[$];
  assign rd_ready = !stall;
  always @(posedge clk) begin
    if (rd_valid && rd_ready) got.push_back(rd_entry);
  end
endmodule
`default_nettype wire

/* File: bench/ptp_peer_and_two_step_tc_stamper_bench.sv */
/*
  Bench for ptp_stamp_top: frames per mode and message type checked
  byte by byte against a model, stamp FIFO filled then drained.
  Assumes default lookahead and a FIFO depth of two.
*/
`timescale 1ns/1ns
`default_nettype none
module ptp_peer_and_two_step_tc_stamper_bench
  import ptp_stamp_pkg::*;
;
  logic clk = 0, rst_n = 0, eg = 0, t3 = 0, stall = 1;
  logic drop, full, rd_valid, rd_ready;
  logic [31:0] stamp = 0, loc = 0, asy = 0, pth = 0;
  beat_type in_beat = '0, out_beat;
  tc_mode_type mode = MODE_PEER_A;
  stamp_action_type act_o;
  ts_entry_type rd_entry, expq[$];
  logic [7:0] oq[$];
  int n_fail = 0, comparisons = 0, seed = 70, drops = 0, exp_drops = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (out_beat.valid) oq.push_back(out_beat.data);
    if (drop) drops++;
  end
  ptp_stamp_top #(.TS_DEPTH(2)) u_dut (.CORE_CLK(clk), .RESET_N(rst_n),
    .IN_BEAT(in_beat), .STAMP_NS(stamp), .TC_MODE(mode), .EGRESS(eg),
    .T3_FIFO_MODE(t3), .DOMAIN(8'h05), .LOCAL_OFFSET(loc), .ASYMMETRY(asy),
    .PATH_DELAY(pth), .OUT_BEAT(out_beat), .FRAME_ACTION(act_o),
    .TS_DROPPED(drop), .TS_FULL(full), .TS_RD_VALID(rd_valid),
    .TS_RD_READY(rd_ready), .TS_RD_ENTRY(rd_entry));
  ts_engine u_eng (.clk(clk), .stall(stall), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_entry(rd_entry));
  task automatic chk(input logic [111:0] got, input logic [111:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] fcs_of(input logic [7:0] b[64]);
    logic [31:0] c = CRC_INIT;
    for (int i = 0; i < 60; i++) begin
      c = c ^ b[i];
      for (int k = 0; k < 8; k++) c = (c >> 1) ^ (c[0] ? CRC_POLY : 32'h0);
    end
    return ~c;
  endfunction
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic run(input tc_mode_type m, input logic e, input logic t,
                     input logic [3:0] msg, input logic ok);
    logic [7:0] fr[64], ex[64];
    logic [63:0] cf;
    logic [31:0] raw, rsv, lo, as, pa, d, nr, st;
    logic wcf, wrv, sv, a2;
    stamp_action_type act, fa;
    for (int i = 0; i < 64; i++) fr[i] = 8'($random(seed));
    raw = {16'h1000, 16'($random(seed))};
    {lo, as, pa, rsv} = {16'h0, 16'($random(seed)), 16'h0, 16'($random(seed)),
      16'h0, 16'($random(seed)), 16'h0, 16'($random(seed))};
    cf = {32'($random(seed)), 32'($random(seed))};
    {fr[12], fr[13], fr[18]} = {16'h88F7, ok ? 8'h05 : 8'h06};
    fr[14] = {fr[14][7:4], msg};
    for (int i = 0; i < 8; i++) fr[22 + i] = cf[63 - 8 * i -: 8];
    for (int i = 0; i < 4; i++) fr[30 + i] = rsv[31 - 8 * i -: 8];
    // Response frames arrive with a broken FCS, which must stay broken
    {fr[63], fr[62], fr[61], fr[60]} = fcs_of(fr) ^ {31'h0, msg == 4'h3};
    {wcf, wrv, sv, d, nr, st, act} = {3'h0, 96'h0, ACT_NONE};
    a2 = (m == MODE_PEER_A);
    if (!ok) act = ACT_NONE;
    else if (m == MODE_TWO_STEP && e) begin
      {act, wrv, sv} = {ACT_WRITE_SAVE, 2'h3};
      st = raw + lo - (msg == 4'h1 ? as : 32'h0);
    end else if (m == MODE_TWO_STEP) begin
      {act, wrv, wcf, nr, d} = {ACT_WRITE, 1'b1, msg == 4'h0, raw - lo, as};
    end else if (e && msg == 4'h0) begin
      {act, wcf, d} = {ACT_ADD, 1'b1, raw + lo};
    end else if (e && msg == 4'h2 && (t || !a2)) begin
      {act, sv, st} = {ACT_WRITE_SAVE, 1'b1, raw + lo - as};
    end else if (e && msg == 4'h2) begin
      {act, wcf, d} = {ACT_SUB_ADD, 1'b1, raw + lo - as - rsv};
    end else if (e) begin
      act = a2 ? ACT_SUB_ADD : ACT_ADD;
      {wcf, d} = {1'b1, raw + lo - (a2 ? rsv : 32'h0)};
    end else if (msg == 4'h0) begin
      {act, wcf, d} = {ACT_PEER_SUB, 1'b1, -(raw - lo - pa - as)};
    end else begin
      {act, wrv, wcf, d} = {ACT_WRITE, 1'b1, a2 && msg == 4'h3, as};
      nr = raw - lo + (msg == 4'h3 && !a2 ? as : 32'h0);
    end
    ex = fr;
    cf = cf + {{16{d[31]}}, d, 16'h0000};
    for (int i = 0; i < 8; i++) if (wcf) ex[22 + i] = cf[63 - 8 * i -: 8];
    for (int i = 0; i < 4; i++) if (wrv) ex[30 + i] = nr[31 - 8 * i -: 8];
    if (wcf || wrv)
      {ex[63], ex[62], ex[61], ex[60]} = fcs_of(ex) ^ {32{msg == 4'h3}};
    @(posedge clk);
    {mode, eg, t3} <= {m, e, t};
    {loc, asy, pth, stamp} <= {lo, as, pa, raw};
    oq.delete();
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      if (i == 50) fa = act_o;
      in_beat <= '{1'b1, i == 0, i == 63, fr[i]};
    end
    @(posedge clk);
    in_beat <= '0;
    repeat (40) @(posedge clk);
    chk(fa, act);
    chk(oq.size(), 64);
    for (int i = 0; i < 64; i++)
      chk(oq[i], ex[i]);
    // Model keeps two entries, the depth the bench sets
    if (sv && expq.size() < 2)
      expq.push_back({fr[44], fr[45], rsv, fr[42], fr[43], 8'h05, 4'h0,
                      msg, st});
    else if (sv) exp_drops++;
    $display("test mode %0h egress %0d msg %0d done", m, e, msg);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    run(MODE_PEER_A, 1, 0, 4'h0, 1);
    run(MODE_PEER_A, 1, 0, 4'h2, 1);
    run(MODE_PEER_A, 1, 0, 4'h3, 1);
    run(MODE_TWO_STEP, 1, 0, 4'h1, 1);
    run(MODE_PEER_B, 1, 0, 4'h2, 1);
    run(MODE_PEER_A, 1, 1, 4'h2, 1);
    run(MODE_TWO_STEP, 1, 0, 4'h0, 1);
    run(MODE_PEER_B, 1, 0, 4'h3, 1);
    run(MODE_PEER_B, 0, 0, 4'h0, 1);
    run(MODE_PEER_B, 0, 0, 4'h2, 1);
    run(MODE_PEER_B, 0, 0, 4'h3, 1);
    run(MODE_PEER_A, 0, 0, 4'h3, 1);
    run(MODE_TWO_STEP, 0, 0, 4'h0, 1);
    run(MODE_TWO_STEP, 0, 0, 4'h1, 1);
    run(MODE_PEER_A, 1, 0, 4'h0, 0);
    chk(full, 1'b1);
    chk(drops, exp_drops);
    stall <= 0;
    repeat (10) @(posedge clk);
    chk(u_eng.got.size(), expq.size());
    foreach (expq[i])
      chk(u_eng.got[i], expq[i]);
    chk(rd_valid, 1'b0);
    end_sim;
  end
  initial begin
    #100000;
    n_fail++;
    end_sim;
  end
endmodule
`default_nettype wire
